/* design/svso_pkg.sv */
package svso_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned ENC_WAIT_MS      = 100;
  localparam int unsigned ENC_WAIT_CYC     = (CLK_HZ / 1000) * ENC_WAIT_MS;
  localparam int unsigned SER_BAUD         = 9600;
  localparam int unsigned SER_BIT_CYC      = CLK_HZ / SER_BAUD;
  localparam int unsigned SER_FRAME_BITS   = 10;
  localparam int unsigned ALM_CHARS        = 3;

  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_ALLOC        = 8'h04;
  localparam logic [7:0]  OFS_ROT_LEVEL    = 8'h08;
  localparam logic [7:0]  OFS_MATCH_WIDTH  = 8'h0c;
  localparam logic [7:0]  OFS_DIV          = 8'h10;
  localparam logic [7:0]  OFS_STATUS       = 8'h14;
  localparam logic [7:0]  OFS_COUNT        = 8'h18;
  localparam logic [7:0]  OFS_FAULT_CODE   = 8'h1c;

  localparam int unsigned CTRL_ABS_BIT     = 0;
  localparam int unsigned CTRL_SPEED_BIT   = 1;
  localparam int unsigned ALLOC_WARN_BIT   = 0;
  localparam int unsigned ALLOC_ROT_BIT    = 1;
  localparam int unsigned ALLOC_RDY_BIT    = 2;
  localparam int unsigned ALLOC_MATCH_BIT  = 3;
  localparam int unsigned ST_FAULT_BIT     = 0;
  localparam int unsigned ST_TX_BIT        = 1;
  localparam int unsigned ST_SEQ_BIT       = 2;
  localparam int unsigned ST_REFUSED_BIT   = 3;
  localparam int unsigned ST_CONTACT_LSB   = 4;

  localparam logic [1:0]  CTRL_RESET       = 2'h3;
  localparam logic [3:0]  ALLOC_RESET      = 4'h0;
  localparam logic [13:0] ROT_LEVEL_MIN    = 14'h0001;
  localparam logic [13:0] ROT_LEVEL_MAX    = 14'h2710;
  localparam logic [13:0] ROT_LEVEL_RESET  = 14'h0014;
  localparam logic [6:0]  MATCH_WIDTH_MAX  = 7'h64;
  localparam logic [6:0]  MATCH_WIDTH_RESET = 7'h0a;
  localparam logic [7:0]  DIV_RESET        = 8'h01;
  localparam logic [6:0]  ASCII_CR         = 7'h0d;

  typedef enum logic [1:0] {
    SVSO_ENC_OFF,
    SVSO_ENC_WAIT,
    SVSO_ENC_AWAIT_DATA,
    SVSO_ENC_READY
  } svso_enc_state_t;

  typedef enum logic [1:0] {
    SVSO_ALM_IDLE,
    SVSO_ALM_LOAD,
    SVSO_ALM_WAIT
  } svso_alm_state_t;

endpackage

/* design/svso_ser_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module svso_ser_tx
  import svso_pkg::*;
#(
  parameter int unsigned BIT_CYC = SER_BIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       start_i,
  input  wire logic [6:0] data_i,
  output logic            txd_o,
  output logic            busy_o
);

  logic [10:0] bit_cnt_ff;
  logic [3:0]  bit_idx_ff;
  logic [9:0]  shift_ff;

  // Frame is start, seven data bits LSB first, even parity, stop.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy_o     <= 1'b0;
      txd_o      <= 1'b1;
      bit_cnt_ff <= 11'h000;
      bit_idx_ff <= 4'h0;
      shift_ff   <= 10'h3ff;
    end else if (!busy_o) begin
      txd_o <= 1'b1;
      if (start_i) begin
        busy_o     <= 1'b1;
        shift_ff   <= {1'b1, ^data_i, data_i, 1'b0};
        txd_o      <= 1'b0;
        bit_cnt_ff <= 11'h000;
        bit_idx_ff <= 4'h0;
      end
    end else if (bit_cnt_ff == 11'(BIT_CYC - 1)) begin
      bit_cnt_ff <= 11'h000;
      if (bit_idx_ff == 4'(SER_FRAME_BITS - 1)) begin
        busy_o <= 1'b0;
        txd_o  <= 1'b1;
      end else begin
        bit_idx_ff <= bit_idx_ff + 4'h1;
        txd_o      <= shift_ff[bit_idx_ff + 4'h1];
      end
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 11'h001;
    end
  end

endmodule
`default_nettype wire

/* design/svso_status_out.sv */
`timescale 1ns/1ps
`default_nettype none
module svso_status_out
  import svso_pkg::*;
#(
  parameter int unsigned ENC_WAIT = ENC_WAIT_CYC,
  parameter int unsigned BIT_CYC  = SER_BIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [31:0] rd_data_o,
  input  wire logic        main_power_i,
  input  wire logic        motor_power_i,
  input  wire logic        hardwired_base_block_i,
  input  wire logic        fault_detect_i,
  input  wire logic [7:0]  fault_code_i,
  input  wire logic        warning_i,
  input  wire logic [15:0] motor_speed_i,
  input  wire logic [15:0] ref_speed_i,
  input  wire logic        enc_pulse_i,
  input  wire logic        enc_dir_i,
  input  wire logic        abs_data_done_i,
  input  wire logic        encoder_power_on_cmd_i,
  input  wire logic        encoder_power_off_cmd_i,
  input  wire logic        fault_clear_cmd_i,
  output logic             fault_contact_o,
  output logic             warning_contact_o,
  output logic             rotation_detect_contact_o,
  output logic             servo_ready_contact_o,
  output logic             speed_match_contact_o,
  output logic             phase_a_pulse_out_o
);

  logic [1:0]      ctrl_ff;
  logic [3:0]      alloc_ff;
  logic [13:0]     rot_level_ff;
  logic [6:0]      match_width_ff;
  logic [7:0]      div_ff;
  logic            fault_latched_ff;
  logic [7:0]      fault_code_ff;
  logic            refused_ff;
  logic [15:0]     updown_cnt_ff;
  logic [7:0]      div_cnt_ff;
  logic            div_phase_ff;
  logic [19:0]     wait_cnt_ff;
  svso_enc_state_t enc_state_ff;
  svso_enc_state_t nxt_enc_state;
  svso_alm_state_t alm_state_ff;
  logic [1:0]      alm_idx_ff;
  logic            ser_start_ff;
  logic [6:0]      ser_char;
  logic            ser_txd;
  logic            ser_busy;
  logic            abs_en;
  logic            speed_mode;
  logic            off_accept;
  logic [15:0]     motor_mag;
  logic [15:0]     ref_mag;
  logic [15:0]     speed_diff;
  logic [31:0]     wr_value;
  logic [31:0]     status_word;

  assign abs_en     = ctrl_ff[CTRL_ABS_BIT];
  assign speed_mode = ctrl_ff[CTRL_SPEED_BIT];
  assign wr_value   = wr_data_i;

  // Power-off is taken only with the motor de-energised and no transfer running.
  assign off_accept = encoder_power_off_cmd_i && abs_en && !motor_power_i &&
                      (alm_state_ff == SVSO_ALM_IDLE);

  function automatic logic [6:0] hex_ascii(input logic [3:0] nib);
    logic [6:0] res;
    res = (nib < 4'ha) ? (7'h30 + {3'h0, nib}) : (7'h37 + {3'h0, nib});
    return res;
  endfunction

  function automatic logic [15:0] mag(input logic [15:0] v);
    logic [15:0] res;
    res = v[15] ? (16'h0000 - v) : v;
    return res;
  endfunction

  // Both directions compare alike, so a negative speed counts by its size.
  assign motor_mag  = mag(motor_speed_i);
  assign ref_mag    = mag(ref_speed_i);
  assign speed_diff = (ref_mag > motor_mag) ? (ref_mag - motor_mag) : (motor_mag - ref_mag);

  // Software configuration; out-of-range levels are clamped so the setting
  // always lands inside the legal range and takes effect at once.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_ff        <= CTRL_RESET;
      alloc_ff       <= ALLOC_RESET;
      rot_level_ff   <= ROT_LEVEL_RESET;
      match_width_ff <= MATCH_WIDTH_RESET;
      div_ff         <= DIV_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        OFS_CTRL: begin
          ctrl_ff <= wr_value[1:0];
        end
        OFS_ALLOC: begin
          alloc_ff <= wr_value[3:0];
        end
        OFS_ROT_LEVEL: begin
          if (wr_value < 32'(ROT_LEVEL_MIN)) begin
            rot_level_ff <= ROT_LEVEL_MIN;
          end else if (wr_value > 32'(ROT_LEVEL_MAX)) begin
            rot_level_ff <= ROT_LEVEL_MAX;
          end else begin
            rot_level_ff <= wr_value[13:0];
          end
        end
        OFS_MATCH_WIDTH: begin
          if (wr_value > 32'(MATCH_WIDTH_MAX)) begin
            match_width_ff <= MATCH_WIDTH_MAX;
          end else begin
            match_width_ff <= wr_value[6:0];
          end
        end
        OFS_DIV: begin
          div_ff <= (wr_value[7:0] == 8'h00) ? 8'h01 : wr_value[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Alarm latch; a new fault in the clear cycle keeps the latch set.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fault_latched_ff <= 1'b0;
      fault_code_ff    <= 8'h00;
    end else begin
      if (fault_detect_i) begin
        fault_latched_ff <= 1'b1;
      end else if (fault_clear_cmd_i) begin
        fault_latched_ff <= 1'b0;
      end
      if (fault_detect_i && !fault_latched_ff) begin
        fault_code_ff <= fault_code_i;
      end
    end
  end

  // Sticky record of a refused power-off; write one to its status bit to clear.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      refused_ff <= 1'b0;
    end else if (encoder_power_off_cmd_i && abs_en && motor_power_i) begin
      refused_ff <= 1'b1;
    end else if (wr_en_i && addr_i == OFS_STATUS && wr_value[ST_REFUSED_BIT]) begin
      refused_ff <= 1'b0;
    end
  end

  // Encoder power sequence.
  always_comb begin
    nxt_enc_state = enc_state_ff;
    case (enc_state_ff)
      SVSO_ENC_OFF: begin
        if (encoder_power_on_cmd_i) begin
          nxt_enc_state = SVSO_ENC_WAIT;
        end
      end
      SVSO_ENC_WAIT: begin
        if (wait_cnt_ff == 20'(ENC_WAIT - 1)) begin
          nxt_enc_state = SVSO_ENC_AWAIT_DATA;
        end
      end
      SVSO_ENC_AWAIT_DATA: begin
        if (abs_data_done_i) begin
          nxt_enc_state = SVSO_ENC_READY;
        end
      end
      SVSO_ENC_READY: begin
      end
      default: begin
        nxt_enc_state = SVSO_ENC_OFF;
      end
    endcase
    if (off_accept) begin
      nxt_enc_state = SVSO_ENC_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enc_state_ff <= SVSO_ENC_OFF;
      wait_cnt_ff  <= 20'h00000;
    end else begin
      enc_state_ff <= nxt_enc_state;
      if (enc_state_ff == SVSO_ENC_WAIT) begin
        wait_cnt_ff <= wait_cnt_ff + 20'h00001;
      end else begin
        wait_cnt_ff <= 20'h00000;
      end
    end
  end

  // Incremental up/down counter, cleared when the wait after power-on ends.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      updown_cnt_ff <= 16'h0000;
    end else if (enc_state_ff == SVSO_ENC_WAIT && nxt_enc_state == SVSO_ENC_AWAIT_DATA) begin
      updown_cnt_ff <= 16'h0000;
    end else if (enc_pulse_i) begin
      updown_cnt_ff <= enc_dir_i ? (updown_cnt_ff - 16'h0001) : (updown_cnt_ff + 16'h0001);
    end
  end

  // One divider serves initial and normal pulses alike, so the host sees
  // the same scaling for both.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_cnt_ff   <= 8'h00;
      div_phase_ff <= 1'b0;
    end else if (enc_pulse_i) begin
      if (div_cnt_ff >= div_ff - 8'h01) begin
        div_cnt_ff   <= 8'h00;
        div_phase_ff <= !div_phase_ff;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
  end

  // Alarm content transfer: two hex digits of the code, then a carriage return.
  always_comb begin
    case (alm_idx_ff)
      2'h0: ser_char = hex_ascii(fault_code_ff[7:4]);
      2'h1: ser_char = hex_ascii(fault_code_ff[3:0]);
      default: ser_char = ASCII_CR;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      alm_state_ff <= SVSO_ALM_IDLE;
      alm_idx_ff   <= 2'h0;
      ser_start_ff <= 1'b0;
    end else begin
      ser_start_ff <= 1'b0;
      case (alm_state_ff)
        SVSO_ALM_IDLE: begin
          alm_idx_ff <= 2'h0;
          if (off_accept) begin
            alm_state_ff <= SVSO_ALM_LOAD;
          end
        end
        SVSO_ALM_LOAD: begin
          ser_start_ff <= 1'b1;
          alm_state_ff <= SVSO_ALM_WAIT;
        end
        SVSO_ALM_WAIT: begin
          // The start pulse is still high in the first wait cycle, before busy rises.
          if (!ser_start_ff && !ser_busy) begin
            if (alm_idx_ff == 2'(ALM_CHARS - 1)) begin
              alm_state_ff <= SVSO_ALM_IDLE;
            end else begin
              alm_idx_ff   <= alm_idx_ff + 2'h1;
              alm_state_ff <= SVSO_ALM_LOAD;
            end
          end
        end
        default: begin
          alm_state_ff <= SVSO_ALM_IDLE;
        end
      endcase
    end
  end

  svso_ser_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_ser_tx (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (ser_start_ff),
    .data_i    (ser_char),
    .txd_o     (ser_txd),
    .busy_o    (ser_busy)
  );

  // Contact outputs; a high level means the contact is closed.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fault_contact_o           <= 1'b0;
      warning_contact_o         <= 1'b0;
      rotation_detect_contact_o <= 1'b0;
      servo_ready_contact_o     <= 1'b0;
      speed_match_contact_o     <= 1'b0;
      phase_a_pulse_out_o       <= 1'b0;
    end else begin
      // Opens in the cycle after detection, before the latch itself is seen.
      fault_contact_o <= !fault_latched_ff && !fault_detect_i;
      warning_contact_o <= alloc_ff[ALLOC_WARN_BIT] && warning_i;
      rotation_detect_contact_o <= alloc_ff[ALLOC_ROT_BIT] &&
                                   (motor_mag >= {2'h0, rot_level_ff});
      servo_ready_contact_o <= alloc_ff[ALLOC_RDY_BIT] && main_power_i &&
                               !hardwired_base_block_i && !fault_latched_ff &&
                               !fault_detect_i &&
                               (!abs_en || enc_state_ff == SVSO_ENC_READY);
      speed_match_contact_o <= alloc_ff[ALLOC_MATCH_BIT] && speed_mode &&
                               (speed_diff < {9'h000, match_width_ff});
      if (alm_state_ff != SVSO_ALM_IDLE) begin
        phase_a_pulse_out_o <= ser_txd;
      end else begin
        phase_a_pulse_out_o <= div_phase_ff;
      end
    end
  end

  assign status_word = {23'h000000,
                        servo_ready_contact_o, speed_match_contact_o,
                        rotation_detect_contact_o, warning_contact_o, fault_contact_o,
                        refused_ff, (enc_state_ff == SVSO_ENC_READY),
                        (alm_state_ff != SVSO_ALM_IDLE), fault_latched_ff};

  // Read data stand for exactly one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 32'h00000000;
    end else if (rd_en_i) begin
      case (addr_i)
        OFS_CTRL:        rd_data_o <= {30'h00000000, ctrl_ff};
        OFS_ALLOC:       rd_data_o <= {28'h0000000, alloc_ff};
        OFS_ROT_LEVEL:   rd_data_o <= {18'h00000, rot_level_ff};
        OFS_MATCH_WIDTH: rd_data_o <= {25'h0000000, match_width_ff};
        OFS_DIV:         rd_data_o <= {24'h000000, div_ff};
        OFS_STATUS:      rd_data_o <= status_word;
        OFS_COUNT:       rd_data_o <= {16'h0000, updown_cnt_ff};
        OFS_FAULT_CODE:  rd_data_o <= {24'h000000, fault_code_ff};
        default:         rd_data_o <= 32'h00000000;
      endcase
    end else begin
      rd_data_o <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

/* bench/svso_status_out_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module svso_status_out_asserts
  import svso_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        main_power_i,
  input wire logic        hardwired_base_block_i,
  input wire logic        fault_detect_i,
  input wire logic        warning_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic [15:0] ref_speed_i,
  input wire logic        abs_data_done_i,
  input wire logic        encoder_power_on_cmd_i,
  input wire logic        fault_clear_cmd_i,
  input wire logic        fault_contact_o,
  input wire logic        warning_contact_o,
  input wire logic        rotation_detect_contact_o,
  input wire logic        servo_ready_contact_o,
  input wire logic        speed_match_contact_o
);
  logic [1:0]  ctrl_ff;
  logic [3:0]  alloc_ff;
  logic [13:0] lvl_ff;
  logic [6:0]  wid_ff;
  logic [1:0]  live_ff;
  logic        done_ff;
  logic [15:0] m_mag;
  logic [15:0] r_mag;
  logic [15:0] diff;
  logic        warn_exp;
  logic        rot_exp;
  logic        match_exp;
  logic        live;

  // Settings are mirrored here so the contact checks know the thresholds in force.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_ff  <= CTRL_RESET;
      alloc_ff <= ALLOC_RESET;
      lvl_ff   <= ROT_LEVEL_RESET;
      wid_ff   <= MATCH_WIDTH_RESET;
    end else if (wr_en_i) begin
      if (addr_i == OFS_CTRL) ctrl_ff <= wr_data_i[1:0];
      if (addr_i == OFS_ALLOC) alloc_ff <= wr_data_i[3:0];
      // The whole word is judged, so a large write clamps instead of wrapping.
      if (addr_i == OFS_ROT_LEVEL) lvl_ff <= (wr_data_i < 32'(ROT_LEVEL_MIN)) ? ROT_LEVEL_MIN :
          (wr_data_i > 32'(ROT_LEVEL_MAX)) ? ROT_LEVEL_MAX : wr_data_i[13:0];
      if (addr_i == OFS_MATCH_WIDTH) wid_ff <= (wr_data_i > 32'(MATCH_WIDTH_MAX)) ?
          MATCH_WIDTH_MAX : wr_data_i[6:0];
    end
  end

  // All contact checks but ready_abs_a wait for the fourth edge after reset, when the pipeline is full.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      live_ff <= 2'h0;
      done_ff <= 1'b0;
    end else begin
      live_ff <= live ? live_ff : live_ff + 2'h1;
      done_ff <= !encoder_power_on_cmd_i && (done_ff || abs_data_done_i);
    end
  end

  assign live      = (live_ff == 2'h3);
  assign m_mag     = motor_speed_i[15] ? 16'h0 - motor_speed_i : motor_speed_i;
  assign r_mag     = ref_speed_i[15] ? 16'h0 - ref_speed_i : ref_speed_i;
  assign diff      = (m_mag > r_mag) ? m_mag - r_mag : r_mag - m_mag;
  assign warn_exp  = alloc_ff[0] && warning_i;
  assign rot_exp   = alloc_ff[1] && (m_mag >= {2'h0, lvl_ff});
  assign match_exp = alloc_ff[3] && ctrl_ff[1] && (diff < {9'h0, wid_ff});

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  fault_open_a: assert property (live && fault_detect_i |=> !fault_contact_o)
    else $error("fault contact not open");
  fault_hold_a: assert property (live && fault_detect_i ##1 !fault_clear_cmd_i [*3]
    |=> !fault_contact_o) else $error("fault contact closed early");
  fault_close_a: assert property (live && fault_clear_cmd_i && !fault_detect_i
    ##1 !fault_detect_i |=> fault_contact_o) else $error("fault contact not closed");
  warn_map_a: assert property (live |=> warning_contact_o == $past(warn_exp))
    else $error("warning contact wrong");
  rot_level_a: assert property (live |=> rotation_detect_contact_o == $past(rot_exp))
    else $error("rotation contact wrong");
  speed_match_a: assert property (live |=> speed_match_contact_o == $past(match_exp))
    else $error("speed match contact wrong");
  ready_block_a: assert property (live && (!main_power_i || hardwired_base_block_i
    || fault_detect_i) |=> !servo_ready_contact_o) else $error("ready contact closed");
  ready_abs_a: assert property ($rose(servo_ready_contact_o) && ctrl_ff[0] |-> done_ff)
    else $error("ready before data done");

  cover property (fault_detect_i ##[1:40] fault_clear_cmd_i);
  cover property ($rose(servo_ready_contact_o));
  cover property ($rose(speed_match_contact_o));
endmodule

bind svso_status_out svso_status_out_asserts u_chk (
  .clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_en_i, .main_power_i, .hardwired_base_block_i,
  .fault_detect_i, .warning_i, .motor_speed_i, .ref_speed_i, .abs_data_done_i,
  .encoder_power_on_cmd_i, .fault_clear_cmd_i, .fault_contact_o, .warning_contact_o,
  .rotation_detect_contact_o, .servo_ready_contact_o, .speed_match_contact_o
);
`default_nettype wire

/* bench/svso_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module svso_host_model #(
  parameter int unsigned BIT_CYC = 8
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] req_i,
  input  wire logic       power_req_i,
  input  wire logic       rx_en_i,
  input  wire logic       fault_contact_i,
  input  wire logic       phase_a_i,
  output logic            on_cmd_o,
  output logic            off_cmd_o,
  output logic            clr_cmd_o,
  output logic            main_power_o,
  output logic [6:0]      rx_char_o,
  output logic            rx_ok_o,
  output logic [3:0]      rx_cnt_o
);
  logic [9:0] sh;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      {clr_cmd_o, off_cmd_o, on_cmd_o} <= 3'h0;
    end else begin
      {clr_cmd_o, off_cmd_o, on_cmd_o} <= req_i;
    end
  end

  // The host drops the main supply whenever the fault contact opens.
  assign main_power_o = power_req_i && fault_contact_i;

  // Sampling mid-bit keeps the receiver clear of the edges where the line moves.
  initial begin
    rx_cnt_o  = 4'h0;
    rx_char_o = 7'h0;
    rx_ok_o   = 1'b0;
    forever begin
      @(negedge phase_a_i iff rx_en_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
        sh[i] = phase_a_i;
        if (i < 9) repeat (BIT_CYC) @(posedge clk_i);
      end
      rx_char_o = sh[7:1];
      rx_ok_o   = !sh[0] && sh[9] && !(^sh[8:1]);
      rx_cnt_o  = rx_cnt_o + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/svso_status_out_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module svso_status_out_tb_top
  import svso_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, motor_pow = 1'b0;
  logic        bb = 1'b0, fdet = 1'b0, warn = 1'b0, epulse = 1'b0, adone = 1'b0, rx_en = 1'b0;
  logic        edir = 1'b0;
  logic [7:0]  addr = 8'h0, fcode = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] mspd = 16'h0, rspd = 16'h0, lv, wd, mo, rf, lc, wc, dd;
  logic [2:0]  req = 3'h0;
  logic        fcon, wcon, rcon, scon, mcon, pha, on_cmd, off_cmd, clr_cmd, mpow, rxok, sp;
  logic [6:0]  rxc;
  logic [3:0]  rxn;
  logic [7:0]  rxq[$], ec[3];
  logic [63:0] corner[4] = '{64'h0014_000a_0014_001e, 64'h0014_000a_ffed_ffe4,
                             64'h0000_0000_0000_0000, 64'h2ee0_0078_2710_d88d};
  int          bad_count = 0, n_tests = 0, tog = 0;

  svso_status_out #(.ENC_WAIT(20), .BIT_CYC(8)) dut (
    .clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .rd_data_o(rdata), .main_power_i(mpow), .motor_power_i(motor_pow),
    .hardwired_base_block_i(bb), .fault_detect_i(fdet), .fault_code_i(fcode), .warning_i(warn),
    .motor_speed_i(mspd), .ref_speed_i(rspd), .enc_pulse_i(epulse), .enc_dir_i(edir),
    .abs_data_done_i(adone), .encoder_power_on_cmd_i(on_cmd), .encoder_power_off_cmd_i(off_cmd),
    .fault_clear_cmd_i(clr_cmd), .fault_contact_o(fcon), .warning_contact_o(wcon),
    .rotation_detect_contact_o(rcon), .servo_ready_contact_o(scon), .speed_match_contact_o(mcon),
    .phase_a_pulse_out_o(pha));
  svso_host_model #(.BIT_CYC(8)) host (
    .clk_i(clk), .reset_n_i(rst_n), .req_i(req), .power_req_i(1'b1), .rx_en_i(rx_en),
    .fault_contact_i(fcon), .phase_a_i(pha), .on_cmd_o(on_cmd), .off_cmd_o(off_cmd),
    .clr_cmd_o(clr_cmd), .main_power_o(mpow), .rx_char_o(rxc), .rx_ok_o(rxok), .rx_cnt_o(rxn));

  always #50 clk = ~clk;
  always @(pha) tog++;
  always @(rxn) if (rx_en) rxq.push_back({rxok, rxc});

  function automatic logic [15:0] mag(logic [15:0] v);
    return v[15] ? 16'h0 - v : v;
  endfunction
  function automatic logic [7:0] hexc(logic [3:0] n);
    return (n < 4'ha) ? 8'hb0 + n : 8'hb7 + n;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(n, e, rdata & m);
  endtask
  task automatic cmd(logic [2:0] c);
    @(posedge clk);
    req <= c;
    @(posedge clk);
    req <= 3'h0;
  endtask
  task automatic sett;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    stop_test;
  end

  initial begin
    void'($urandom(32'hd109d04b));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc("ctrl", OFS_CTRL, 32'h3);
    rc("level", OFS_ROT_LEVEL, 32'h14);
    rc("width", OFS_MATCH_WIDTH, 32'ha);
    rc("unmapped", 8'h20, 32'h0);
    @(posedge clk);
    warn <= 1'b1;
    sett;
    chk("warn", 32'h0, {31'h0, wcon});
    wr(OFS_ALLOC, 32'hf);
    sett;
    chk("warn", 32'h1, {31'h0, wcon});
    @(posedge clk);
    warn <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      {lv, wd, mo, rf} = corner[k % 4];
      sp = 1'b1;
      if (k >= 4) begin
        lv = 16'($urandom_range(32'h2ee0));
        wd = 16'($urandom_range(32'h7f));
        mo = 16'($urandom_range(32'h5dc0)) - 16'h2ee0;
        rf = mo + 16'($urandom_range(32'h12c)) - 16'h0096;
        sp = 1'($urandom_range(1));
      end
      lc = (lv < 16'(ROT_LEVEL_MIN)) ? 16'(ROT_LEVEL_MIN) :
           ((lv > 16'(ROT_LEVEL_MAX)) ? 16'(ROT_LEVEL_MAX) : lv);
      wc = (wd > 16'(MATCH_WIDTH_MAX)) ? 16'(MATCH_WIDTH_MAX) : wd;
      dd = (mag(mo) > mag(rf)) ? mag(mo) - mag(rf) : mag(rf) - mag(mo);
      wr(OFS_ROT_LEVEL, {16'h0, lv});
      wr(OFS_MATCH_WIDTH, {16'h0, wd});
      wr(OFS_CTRL, {30'h0, sp, 1'b1});
      if (k < 4) rc("level", OFS_ROT_LEVEL, {16'h0, lc});
      if (k < 4) rc("width", OFS_MATCH_WIDTH, {16'h0, wc});
      @(posedge clk);
      mspd <= mo;
      rspd <= rf;
      sett;
      chk("rotation", {31'h0, mag(mo) >= lc}, {31'h0, rcon});
      chk("match", {31'h0, sp && dd < wc}, {31'h0, mcon});
    end
    wr(OFS_DIV, 32'h4);
    tog = 0;
    // The last three pulses count down; the divider must not care about direction.
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      epulse <= 1'b1;
      edir   <= (i >= 9);
      @(posedge clk);
      epulse <= 1'b0;
    end
    sett;
    chk("phase_a_edges", 32'h3, tog);
    rc("count", OFS_COUNT, 32'h6);
    cmd(3'h1);
    repeat (10) @(posedge clk);
    #1 chk("ready", 32'h0, {31'h0, scon});
    repeat (20) @(posedge clk);
    rc("count", OFS_COUNT, 32'h0);
    chk("ready", 32'h0, {31'h0, scon});
    @(posedge clk);
    adone <= 1'b1;
    @(posedge clk);
    adone <= 1'b0;
    sett;
    chk("ready", 32'h1, {31'h0, scon});
    @(posedge clk);
    bb <= 1'b1;
    sett;
    chk("ready", 32'h0, {31'h0, scon});
    @(posedge clk);
    bb        <= 1'b0;
    motor_pow <= 1'b1;
    cmd(3'h2);
    sett;
    rc("status", OFS_STATUS, 32'hc, 32'hf);
    chk("ready", 32'h1, {31'h0, scon});
    wr(OFS_STATUS, 32'h8);
    rc("status", OFS_STATUS, 32'h4, 32'hf);
    @(posedge clk);
    motor_pow <= 1'b0;
    fcode     <= 8'($urandom());
    fdet      <= 1'b1;
    @(posedge clk);
    fdet <= 1'b0;
    sett;
    chk("fault", 32'h0, {31'h0, fcon});
    chk("ready", 32'h0, {31'h0, scon});
    chk("main_power", 32'h0, {31'h0, mpow});
    rc("fault_code", OFS_FAULT_CODE, {24'h0, fcode});
    ec = '{hexc(fcode[7:4]), hexc(fcode[3:0]), {1'b1, ASCII_CR}};
    @(posedge clk);
    rx_en <= 1'b1;
    cmd(3'h2);
    for (int t = 0; t < 1000 && rxq.size() < 3; t++) @(posedge clk);
    chk("chars", 32'h3, rxq.size());
    foreach (rxq[i]) chk("char", {24'h0, ec[i % 3]}, {24'h0, rxq[i]});
    @(posedge clk);
    rx_en <= 1'b0;
    cmd(3'h4);
    sett;
    chk("fault", 32'h1, {31'h0, fcon});
    chk("ready", 32'h0, {31'h0, scon});
    wr(OFS_CTRL, 32'h2);
    sett;
    chk("ready", 32'h1, {31'h0, scon});
    stop_test;
  end
endmodule
`default_nettype wire
